// [common/tws_pkg.sv]
// shared constants and types of the two-wire slave block
// assumes one 125 MHz system clock; register port is 3-bit addressed
package tws_pkg;

	// ==========================================================
	// timing
	localparam int CLK_MHZ      = 125;
	localparam int T_HD_STA_NS  = 4000;
	localparam int T_SU_STO_NS  = 4000;
	localparam int HD_STA_CYC   = (T_HD_STA_NS * CLK_MHZ + 999) / 1000;
	localparam int SU_STO_CYC   = (T_SU_STO_NS * CLK_MHZ + 999) / 1000;

	// ==========================================================
	// register offsets
	localparam int AW = 3;
	localparam logic [AW-1:0] OFF_OWN  = 3'h0;
	localparam logic [AW-1:0] OFF_CTL  = 3'h1;
	localparam logic [AW-1:0] OFF_STAT = 3'h2;
	localparam logic [AW-1:0] OFF_BUF  = 3'h3;
	localparam logic [AW-1:0] OFF_SLP  = 3'h4;

	// ==========================================================
	// field positions
	localparam int CTL_INT  = 7;
	localparam int CTL_ACK  = 6;
	localparam int CTL_BEG  = 5;
	localparam int CTL_HALT = 4;
	localparam int CTL_WCOL = 3;
	localparam int CTL_EN   = 2;
	localparam int CTL_IE   = 0;
	localparam int OWN_GCE  = 0;
	localparam int SLP_DEEP = 0;
	localparam int SLP_WAKE = 1;
	localparam logic [7:0] GC_ADDR = 8'h00;

	// ==========================================================
	// status codes
	localparam logic [7:0] ST_START   = 8'h08;
	localparam logic [7:0] ST_SLA_W   = 8'h60;
	localparam logic [7:0] ST_ARB_W   = 8'h68;
	localparam logic [7:0] ST_GC      = 8'h70;
	localparam logic [7:0] ST_ARB_GC  = 8'h78;
	localparam logic [7:0] ST_RX_ACK  = 8'h80;
	localparam logic [7:0] ST_RX_NACK = 8'h88;
	localparam logic [7:0] ST_GC_ACK  = 8'h90;
	localparam logic [7:0] ST_GC_NACK = 8'h98;
	localparam logic [7:0] ST_HALTED  = 8'hA0;
	localparam logic [7:0] ST_SLA_R   = 8'hA8;
	localparam logic [7:0] ST_ARB_R   = 8'hB0;
	localparam logic [7:0] ST_TX_ACK  = 8'hB8;
	localparam logic [7:0] ST_TX_NACK = 8'hC0;
	localparam logic [7:0] ST_LAST_AK = 8'hC8;
	localparam logic [7:0] ST_NONE    = 8'hF8;

	// ==========================================================
	// types
	typedef struct packed {
		logic scl;
		logic sda;
	} tws_pins_t;

	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} tws_cond_t;

	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_ACK_OUT, S_RX, S_TX, S_ACK_IN, S_HOLD, S_STA
	} tws_state_t;

endpackage

// [logic/tws_sync.sv]
// two-flop synchroniser for the bus lines
// assumes the pins are asynchronous to clk_i and idle high
`timescale 1ns/1ps
module tws_sync (
	input  wire logic              clk_i,     // system clock
	input  wire logic              sys_rst_i, // async reset, high
	input  wire tws_pkg::tws_pins_t pins_i,   // raw line levels
	output tws_pkg::tws_pins_t      pins_o     // synchronised levels
);
	typedef struct packed {
		tws_pkg::tws_pins_t meta;
		tws_pkg::tws_pins_t stab;
	} tws_sync_t;

	tws_sync_t q, n;

	// ==========================================================
	// the first stage feeds only the second
	always_comb begin
		n      = q;
		n.meta = pins_i;
		n.stab = q.meta;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q <= '1;
		end else begin
			q <= n;
		end
	end

	assign pins_o = q.stab;
endmodule

// [logic/tws_cond.sv]
// edge and START/STOP detection on synchronised bus lines
// assumes its input is already in the clk_i domain
`timescale 1ns/1ps
module tws_cond (
	input  wire logic               clk_i,     // system clock
	input  wire logic               sys_rst_i, // async reset, high
	input  wire tws_pkg::tws_pins_t pins_i,    // synchronised lines
	output tws_pkg::tws_cond_t      cond_o     // one-cycle events
);
	typedef struct packed {
		tws_pkg::tws_pins_t prev;
		tws_pkg::tws_cond_t ev;
	} tws_det_t;

	tws_det_t q, n;

	// ==========================================================
	// sda moving while scl stays high marks start or stop
	always_comb begin
		n             = q;
		n.prev        = pins_i;
		n.ev.scl_rise = pins_i.scl & ~q.prev.scl;
		n.ev.scl_fall = ~pins_i.scl & q.prev.scl;
		n.ev.start    = q.prev.scl & pins_i.scl & q.prev.sda & ~pins_i.sda;
		n.ev.stop     = q.prev.scl & pins_i.scl & ~q.prev.sda & pins_i.sda;
		n.ev.sda      = pins_i.sda;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q         <= '0;
			q.prev    <= '1;
			q.ev.sda  <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign cond_o = q.ev;
endmodule

// [logic/tws_slave.sv]
// two-wire bus slave: address match, receive, transmit, status codes
// assumes a simple register port on clk_i and open-drain bus lines
// Function
// - own address sits in the upper seven bits of the address register
// - lowest address bit enables answering the general call address
// - read bit selects transmitter, write bit selects receiver
// - after address and direction, flag rises with a valid code
// - lost start attempt then own read address reports its own code
// - ack enable cleared sends one final byte, then NACK or ACK code
// - after final byte, unaddressed and data line released
// - master ACK after final byte reports final-byte-acknowledged code
// - ack enable low ignores own address yet keeps watching the bus
// - in deep sleep an address match is still acked and wakes
// - after sleep wake, clock held low until flag is cleared
// - after deep sleep byte buffer need not hold the last byte
// - general-call data acked; next byte acked per ack enable
// - general-call data NACKed returns to unaddressed mode
// - stop or repeated start while addressed reports and unaddresses
// - begin request pending at exit sends START once bus is free and flag is cleared
// - after own read address, loaded byte sent, last when ack off
// - acked transmitted byte reports code and waits for next byte
`timescale 1ns/1ps
module tws_slave (
	input  wire logic                    clk_i,      // system clock
	input  wire logic                    sys_rst_i,  // async reset, high
	input  wire logic [tws_pkg::AW-1:0]  addr_i,     // register address
	input  wire logic [7:0]              wr_data_i,  // write data
	input  wire logic                    wr_i,       // write strobe
	input  wire logic                    rd_i,       // read strobe
	output logic      [7:0]              rd_data_o,  // read data, next cycle
	input  wire logic                    scl_i,      // clock line level
	output logic                         scl_o,      // clock line drive level
	output logic                         scl_oe_n_o, // clock pull, low = drive
	input  wire logic                    sda_i,      // data line level
	output logic                         sda_o,      // data line drive level
	output logic                         sda_oe_n_o, // data pull, low = drive
	output logic                         wake_o      // address match in sleep
);
	typedef struct packed {
		tws_pkg::tws_state_t st;
		logic [3:0]          cnt;
		logic [7:0]          sh;
		logic [7:0]          own;
		logic                ack_en;
		logic                beg;
		logic                halt;
		logic                wcol;
		logic                en;
		logic                ie;
		logic                flag;
		logic [1:0]          presc;
		logic [7:0]          code;
		logic [7:0]          bbuf;
		logic                deep;
		logic                wake;
		logic                dir;
		logic                gc;
		logic                arb;
		logic                ack;
		logic                last;
		logic                adr;
		logic                busy;
		logic [1:0]          ph;
		logic [9:0]          tmr;
		logic                sda_pull;
		logic                scl_pull;
		logic                lvl;
		logic [7:0]          rdata;
	} tws_core_t;

	tws_core_t          q, n;
	tws_pkg::tws_pins_t raw, syn;
	tws_pkg::tws_cond_t c;

	// ==========================================================
	// line conditioning
	assign raw.scl = scl_i;
	assign raw.sda = sda_i;

	tws_sync tws_sync_inst (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.pins_i    (raw),
		.pins_o    (syn)
	);

	tws_cond tws_cond_inst (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.pins_i    (syn),
		.cond_o    (c)
	);

	// ==========================================================
	// post an event: set flag and code; exits drop to unaddressed
	function automatic tws_core_t post(input tws_core_t s, input logic [7:0] code,
			input logic ex);
		s.flag     = 1'b1;
		s.code     = code;
		s.sda_pull = 1'b0;
		s.scl_pull = ~ex;
		s.st       = ex ? tws_pkg::S_IDLE : tws_pkg::S_HOLD;
		return s;
	endfunction

	function automatic logic addressed(input tws_pkg::tws_state_t st, input logic adr);
		addressed = (st == tws_pkg::S_RX) || (st == tws_pkg::S_TX) ||
			(st == tws_pkg::S_ACK_IN) || (st == tws_pkg::S_HOLD) ||
			(st == tws_pkg::S_ACK_OUT && !adr);
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic       wr_ctl;
		logic       flag_clr;
		logic       beg_wr;
		logic [7:0] a;
		logic       m_own;
		logic       m_gc;
		n        = q;
		wr_ctl   = wr_i && (addr_i == tws_pkg::OFF_CTL);
		flag_clr = wr_ctl && wr_data_i[tws_pkg::CTL_INT] && q.flag;
		beg_wr   = wr_ctl && wr_data_i[tws_pkg::CTL_BEG];
		a        = {q.sh[6:0], c.sda};
		m_own    = a[7:1] == q.own[7:1];
		m_gc     = (a == tws_pkg::GC_ADDR) && q.own[tws_pkg::OWN_GCE];

		// register writes
		if (wr_i) begin
			case (addr_i)
				tws_pkg::OFF_OWN: begin
					n.own = wr_data_i;
				end
				tws_pkg::OFF_CTL: begin
					n.ack_en = wr_data_i[tws_pkg::CTL_ACK];
					n.beg    = wr_data_i[tws_pkg::CTL_BEG];
					n.halt   = wr_data_i[tws_pkg::CTL_HALT];
					n.en     = wr_data_i[tws_pkg::CTL_EN];
					n.ie     = wr_data_i[tws_pkg::CTL_IE];
					if (wr_data_i[tws_pkg::CTL_INT]) begin
						n.flag = 1'b0;
					end
				end
				tws_pkg::OFF_STAT: begin
					n.presc = wr_data_i[1:0];
				end
				tws_pkg::OFF_BUF: begin
					// a load while the bus is moving would corrupt the shift
					if (q.flag) begin
						n.bbuf = wr_data_i;
					end
					n.wcol = ~q.flag;
				end
				tws_pkg::OFF_SLP: begin
					n.deep = wr_data_i[tws_pkg::SLP_DEEP];
					if (!wr_data_i[tws_pkg::SLP_DEEP]) begin
						n.wake = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// register reads, answered one cycle later
		n.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				tws_pkg::OFF_OWN:  n.rdata = q.own;
				tws_pkg::OFF_CTL:  n.rdata = {q.flag, q.ack_en, q.beg, q.halt,
					q.wcol, q.en, 1'b0, q.ie};
				tws_pkg::OFF_STAT: n.rdata = {q.code[7:3], 1'b0, q.presc};
				tws_pkg::OFF_BUF:  n.rdata = q.bbuf;
				tws_pkg::OFF_SLP:  n.rdata = {6'h00, q.wake, q.deep};
				default:           n.rdata = 8'h00;
			endcase
		end

		// bus-wide conditions
		if (c.stop) begin
			n.busy = 1'b0;
		end
		if (c.start) begin
			n.busy = 1'b1;
		end

		if (!q.en) begin
			n.st       = tws_pkg::S_IDLE;
			n.sda_pull = 1'b0;
			n.scl_pull = 1'b0;
			n.arb      = 1'b0;
		end else if ((c.start || c.stop) && q.st != tws_pkg::S_STA) begin
			if (addressed(q.st, q.adr)) begin
				n = post(n, tws_pkg::ST_HALTED, 1'b1);
			end else if (c.start && q.beg && q.st == tws_pkg::S_IDLE) begin
				// another master won the bus while our start waited
				n.arb = 1'b1;
			end
			if (c.start) begin
				n.st       = tws_pkg::S_ADDR;
				n.cnt      = 4'h0;
				n.sda_pull = 1'b0;
				n.scl_pull = 1'b0;
			end
		end else begin
			case (q.st)
				tws_pkg::S_IDLE: begin
					if (q.beg && !q.busy && !q.flag) begin
						n.st       = tws_pkg::S_STA;
						n.ph       = 2'd0;
						n.tmr      = '0;
						n.sda_pull = 1'b1;
					end
				end
				tws_pkg::S_ADDR: begin
					if (c.scl_rise) begin
						n.sh  = a;
						n.cnt = q.cnt + 4'h1;
						if (q.cnt == 4'h7) begin
							if (q.ack_en && (m_own || m_gc)) begin
								n.st  = tws_pkg::S_ACK_OUT;
								n.dir = a[0];
								n.gc  = ~m_own;
								n.ack = 1'b1;
								n.adr = 1'b1;
								if (q.deep) begin
									n.wake = 1'b1;
								end
							end else begin
								n.st = tws_pkg::S_IDLE;
							end
						end
					end
				end
				tws_pkg::S_ACK_OUT: begin
					if (c.scl_fall && q.cnt == 4'h8) begin
						n.sda_pull = q.ack;
						n.cnt      = 4'h9;
					end else if (c.scl_fall) begin
						if (q.adr) begin
							n.adr = 1'b0;
							n.arb = 1'b0;
							if (q.dir) begin
								n = post(n, q.arb ? tws_pkg::ST_ARB_R : tws_pkg::ST_SLA_R,
									1'b0);
							end else if (q.gc) begin
								n = post(n, q.arb ? tws_pkg::ST_ARB_GC : tws_pkg::ST_GC,
									1'b0);
							end else begin
								n = post(n, q.arb ? tws_pkg::ST_ARB_W : tws_pkg::ST_SLA_W,
									1'b0);
							end
						end else begin
							if (!q.deep) begin
								n.bbuf = q.sh;
							end
							if (q.gc) begin
								n = post(n, q.ack ? tws_pkg::ST_GC_ACK : tws_pkg::ST_GC_NACK,
									~q.ack);
							end else begin
								n = post(n, q.ack ? tws_pkg::ST_RX_ACK : tws_pkg::ST_RX_NACK,
									~q.ack);
							end
						end
					end
				end
				tws_pkg::S_RX: begin
					if (c.scl_rise) begin
						n.sh  = a;
						n.cnt = q.cnt + 4'h1;
						if (q.cnt == 4'h7) begin
							n.st  = tws_pkg::S_ACK_OUT;
							n.ack = q.ack_en;
						end
					end
				end
				tws_pkg::S_TX: begin
					if (c.scl_rise) begin
						n.cnt = q.cnt + 4'h1;
					end else if (c.scl_fall) begin
						if (q.cnt == 4'h8) begin
							n.sda_pull = 1'b0;
							n.st       = tws_pkg::S_ACK_IN;
						end else begin
							n.sh       = {q.sh[6:0], 1'b0};
							n.sda_pull = ~q.sh[6];
						end
					end
				end
				tws_pkg::S_ACK_IN: begin
					if (c.scl_rise) begin
						n.ack = ~c.sda;
						n.cnt = 4'h9;
					end else if (c.scl_fall && q.cnt == 4'h9) begin
						if (q.last) begin
							// ending unaddressed leaves sda released: master reads ones
							n = post(n, q.ack ? tws_pkg::ST_LAST_AK : tws_pkg::ST_TX_NACK,
								1'b1);
						end else begin
							n = post(n, q.ack ? tws_pkg::ST_TX_ACK : tws_pkg::ST_TX_NACK,
								~q.ack);
						end
					end
				end
				tws_pkg::S_HOLD: begin
					// stretching the clock here also covers a wake from sleep
					n.scl_pull = 1'b1;
					if (flag_clr) begin
						n.scl_pull = 1'b0;
						n.cnt      = 4'h0;
						if (n.halt) begin
							n.halt = 1'b0;
							n.st   = tws_pkg::S_IDLE;
						end else if (q.dir) begin
							n.st       = tws_pkg::S_TX;
							n.sh       = q.bbuf;
							n.sda_pull = ~q.bbuf[7];
							n.last     = ~n.ack_en;
						end else begin
							n.st = tws_pkg::S_RX;
						end
					end
				end
				tws_pkg::S_STA: begin
					case (q.ph)
						2'd0: begin
							n.tmr = q.tmr + 10'd1;
							if (q.tmr == 10'(tws_pkg::HD_STA_CYC - 1)) begin
								n.scl_pull = 1'b1;
								n.ph       = 2'd1;
								n.flag     = 1'b1;
								n.code     = tws_pkg::ST_START;
								if (!beg_wr) begin
									n.beg = 1'b0;
								end
							end
						end
						2'd1: begin
							if (flag_clr) begin
								n.scl_pull = 1'b0;
								n.ph       = 2'd2;
								n.tmr      = '0;
							end
						end
						default: begin
							// no master mode: release with a stop after setup time
							n.tmr = q.tmr + 10'd1;
							if (q.tmr == 10'(tws_pkg::SU_STO_CYC - 1)) begin
								n.sda_pull = 1'b0;
								n.st       = tws_pkg::S_IDLE;
							end
						end
					endcase
				end
				default: begin
					n.st = tws_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q      <= '0;
			q.code <= tws_pkg::ST_NONE;
		end else begin
			q <= n;
		end
	end

	assign rd_data_o  = q.rdata;
	assign scl_o      = q.lvl;
	assign sda_o      = q.lvl;
	assign scl_oe_n_o = ~q.scl_pull;
	assign sda_oe_n_o = ~q.sda_pull;
	assign wake_o     = q.wake;
endmodule

// [dv/tws_props.sv]
// port checker for the two-wire slave
// assumes it is bound to tws_slave and sees only its ports
`timescale 1ns/1ps
module tws_props (
	input wire logic                   clk_i,      // system clock
	input wire logic                   sys_rst_i,  // async reset, high
	input wire logic [tws_pkg::AW-1:0] addr_i,     // register address
	input wire logic [7:0]             wr_data_i,  // write data
	input wire logic                   wr_i,       // write strobe
	input wire logic                   rd_i,       // read strobe
	input wire logic [7:0]             rd_data_o,  // read data
	input wire logic                   scl_i,      // clock line
	input wire logic                   scl_o,      // clock drive level
	input wire logic                   scl_oe_n_o, // clock pull, low = drive
	input wire logic                   sda_i,      // data line
	input wire logic                   sda_o,      // data drive level
	input wire logic                   sda_oe_n_o, // data pull, low = drive
	input wire logic                   wake_o      // wake level
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic clr_w;
	logic wclr_w;
	assign clr_w = wr_i && addr_i == tws_pkg::OFF_CTL && wr_data_i[tws_pkg::CTL_INT];
	assign wclr_w = wr_i && addr_i == tws_pkg::OFF_SLP && !wr_data_i[tws_pkg::SLP_DEEP];
	// ==========================================================
	// stretch steps
	sequence s_pull;
		!scl_oe_n_o;
	endsequence
	sequence s_free;
		scl_oe_n_o;
	endsequence
	AST_SCL_ONLY_LOW: assert property (scl_o == 1'b0)
		else $error("clock line driven high");
	AST_SDA_ONLY_LOW: assert property (sda_o == 1'b0)
		else $error("data line driven high");
	AST_STRETCH_HOLDS: assert property (s_pull ##0 !clr_w |=> s_pull)
		else $error("clock released before flag clear");
	AST_STRETCH_ENDS: assert property (s_pull ##0 clr_w |=> s_free)
		else $error("clock still held after flag clear");
	// a start of our own pulls the clock while it is high, with data already low
	AST_STRETCH_WHEN_LOW: assert property ($fell(scl_oe_n_o) && sda_oe_n_o |-> !scl_i)
		else $error("clock pulled while high");
	AST_WAKE_HOLDS: assert property (wake_o && !wclr_w |=> wake_o)
		else $error("wake dropped on its own");
	AST_WAKE_CLEARS: assert property (wclr_w |=> !wake_o)
		else $error("wake not cleared");
	AST_RD_PULSE: assert property (rd_data_o != 8'h00 |-> $past(rd_i))
		else $error("read data outside its cycle");
endmodule

// [dv/tws_master.sv]
// behavioural master on the far side of the two-wire link
// assumes the bench resolves both lines with pull-ups; three 20 ns steps per bit plus any stretch wait
`timescale 1ns/1ps
module tws_master (
	input  wire logic scl_i, // resolved clock line
	input  wire logic sda_i, // resolved data line
	output logic      scl_o, // 0 pulls clock low, 1 releases
	output logic      sda_o  // 0 pulls data low, 1 releases
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// ==========================================================
	// one bit: data set in the low phase, sampled at the end of the high phase
	task automatic bit_x(input logic b, output logic r);
		int n;
		n = 0;
		sda_o = b;
		#20 scl_o = 1'b1;
		// a stretching slave keeps the line low; wait, but bounded
		while (scl_i !== 1'b1 && n < 2000) begin
			#8 n++;
		end
		#20 r = sda_i;
		scl_o = 1'b0;
		#20;
	endtask
	task automatic start_c();
		sda_o = 1'b1;
		#20 scl_o = 1'b1;
		#20 sda_o = 1'b0;
		#40 scl_o = 1'b0;
		#20;
	endtask
	task automatic stop_c();
		sda_o = 1'b0;
		#20 scl_o = 1'b1;
		#40 sda_o = 1'b1;
		#40;
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, ack);
	endtask
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(ack, r);
	endtask
endmodule

// [dv/two_wire_slave_tx_rx_states_tb.sv]
// self-checking bench for the two-wire slave
// assumes tws_master plays the external bus master
`timescale 1ns/1ps
module two_wire_slave_tx_rx_states_tb;
	logic [tws_pkg::AW-1:0] addr_i = 3'h0;
	logic [7:0] wr_data_i = 8'h00;
	logic [7:0] rd_data_o;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, wake_o, m_scl, m_sda;
	wire scl_w;
	wire sda_w;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	// pulled-up lines: any party pulling low wins
	assign scl_w = m_scl & scl_oe_n_o;
	assign sda_w = m_sda & sda_oe_n_o;
	always #4 clk_i = ~clk_i;
	tws_slave tws_slave_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wake_o(wake_o));
	tws_master tws_master_inst (.scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			close_out();
		end
	end
	// ==========================================================
	// shared tasks
	task automatic close_out();
		$display("mismatches %0d, comparisons %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [tws_pkg::AW-1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rreg(input logic [tws_pkg::AW-1:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		d = rd_data_o;
	endtask
	task automatic wait_code(input logic [7:0] exp);
		logic [7:0] v;
		int n;
		v = 8'h00;
		n = 0;
		while (v[tws_pkg::CTL_INT] !== 1'b1 && n < 500) begin
			rreg(tws_pkg::OFF_CTL, v);
			n++;
		end
		chk(v[tws_pkg::CTL_INT], 1'b1);
		rreg(tws_pkg::OFF_STAT, v);
		chk(v & 8'hF8, exp);
	endtask
	// clears the flag and keeps the unit enabled, no start or stop request
	task automatic go(input logic ack);
		wreg(tws_pkg::OFF_CTL, {1'b1, ack, 6'h04});
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [7:0] v;
		rreg(tws_pkg::OFF_OWN, v);
		chk(v, 8'h00);
		rreg(tws_pkg::OFF_STAT, v);
		chk(v, tws_pkg::ST_NONE);
		rreg(3'h5, v);
		chk(v, 8'h00);
	endtask
	task automatic t_noack();
		logic a;
		wreg(tws_pkg::OFF_OWN, 8'h52);
		wreg(tws_pkg::OFF_CTL, 8'h04);
		tws_master_inst.start_c();
		tws_master_inst.put_byte(8'h52, a);
		chk(a, 1'b1);
		tws_master_inst.stop_c();
		wreg(tws_pkg::OFF_CTL, 8'h44);
	endtask
	task automatic t_write();
		logic a;
		logic [7:0] v;
		tws_master_inst.start_c();
		tws_master_inst.put_byte(8'h52, a);
		chk(a, 1'b0);
		wait_code(tws_pkg::ST_SLA_W);
		go(1'b1);
		tws_master_inst.put_byte(8'hA5, a);
		chk(a, 1'b0);
		wait_code(tws_pkg::ST_RX_ACK);
		rreg(tws_pkg::OFF_BUF, v);
		chk(v, 8'hA5);
		go(1'b1);
		tws_master_inst.stop_c();
		wait_code(tws_pkg::ST_HALTED);
		go(1'b1);
	endtask
	task automatic t_gc();
		logic a;
		tws_master_inst.start_c();
		tws_master_inst.put_byte(8'h00, a);
		chk(a, 1'b1);
		tws_master_inst.stop_c();
		wreg(tws_pkg::OFF_OWN, 8'h53);
		tws_master_inst.start_c();
		tws_master_inst.put_byte(8'h00, a);
		chk(a, 1'b0);
		wait_code(tws_pkg::ST_GC);
		go(1'b1);
		tws_master_inst.put_byte(8'h5A, a);
		chk(a, 1'b0);
		wait_code(tws_pkg::ST_GC_ACK);
		go(1'b0);
		tws_master_inst.put_byte(8'h77, a);
		chk(a, 1'b1);
		wait_code(tws_pkg::ST_GC_NACK);
		go(1'b1);
		tws_master_inst.stop_c();
	endtask
	task automatic t_read();
		logic a;
		logic [7:0] v;
		tws_master_inst.start_c();
		tws_master_inst.put_byte(8'h53, a);
		chk(a, 1'b0);
		wait_code(tws_pkg::ST_SLA_R);
		wreg(tws_pkg::OFF_BUF, 8'h3C);
		go(1'b1);
		tws_master_inst.get_byte(1'b0, v);
		chk(v, 8'h3C);
		wait_code(tws_pkg::ST_TX_ACK);
		wreg(tws_pkg::OFF_BUF, 8'hC3);
		go(1'b0);
		tws_master_inst.get_byte(1'b0, v);
		chk(v, 8'hC3);
		wait_code(tws_pkg::ST_LAST_AK);
		go(1'b1);
		tws_master_inst.get_byte(1'b1, v);
		chk(v, 8'hFF);
		tws_master_inst.stop_c();
		tws_master_inst.start_c();
		tws_master_inst.put_byte(8'h53, a);
		wait_code(tws_pkg::ST_SLA_R);
		wreg(tws_pkg::OFF_BUF, 8'h81);
		go(1'b1);
		tws_master_inst.get_byte(1'b1, v);
		chk(v, 8'h81);
		wait_code(tws_pkg::ST_TX_NACK);
		go(1'b1);
		tws_master_inst.stop_c();
	endtask
	task automatic t_sleep();
		logic a;
		wreg(tws_pkg::OFF_SLP, 8'h01);
		tws_master_inst.start_c();
		tws_master_inst.put_byte(8'h52, a);
		chk(a, 1'b0);
		wait_code(tws_pkg::ST_SLA_W);
		chk(wake_o, 1'b1);
		repeat (20) @(posedge clk_i);
		chk(scl_oe_n_o, 1'b0);
		go(1'b1);
		@(negedge clk_i);
		chk(scl_oe_n_o, 1'b1);
		wreg(tws_pkg::OFF_SLP, 8'h00);
		@(negedge clk_i);
		chk(wake_o, 1'b0);
		tws_master_inst.stop_c();
		wait_code(tws_pkg::ST_HALTED);
		go(1'b1);
	endtask
	// begin request pending while a foreign start arrives, then sent once free
	task automatic t_arb();
		logic a;
		logic [7:0] v;
		tws_master_inst.start_c();
		tws_master_inst.put_byte(8'h20, a);
		chk(a, 1'b1);
		wreg(tws_pkg::OFF_CTL, 8'h64);
		tws_master_inst.start_c();
		tws_master_inst.put_byte(8'h53, a);
		chk(a, 1'b0);
		wait_code(tws_pkg::ST_ARB_R);
		wreg(tws_pkg::OFF_BUF, 8'h96);
		wreg(tws_pkg::OFF_CTL, 8'hA4);
		tws_master_inst.get_byte(1'b1, v);
		chk(v, 8'h96);
		wait_code(tws_pkg::ST_TX_NACK);
		tws_master_inst.stop_c();
		wreg(tws_pkg::OFF_CTL, 8'hE4);
		wait_code(tws_pkg::ST_START);
		chk(sda_oe_n_o, 1'b0);
		go(1'b1);
		repeat (tws_pkg::SU_STO_CYC + 10) @(posedge clk_i);
		@(negedge clk_i);
		chk(sda_oe_n_o, 1'b1);
		chk(scl_oe_n_o, 1'b1);
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		t_reset();
		t_noack();
		t_write();
		t_gc();
		t_read();
		t_sleep();
		t_arb();
		close_out();
	end
endmodule
bind tws_slave tws_props tws_props_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
	.rd_data_o(rd_data_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wake_o(wake_o));
